// file: compact_timer_pwm.sv
// Purpose: 10-bit compact timer with compare output, timer and pwm modes
// Assumes: pclk is also the system and high clock; tbc_tick is a pclk pulse
// Notes:   apb slave with zero wait states, registered answers
//
// Operation
// - a 10-bit up-counter is checked by a period and a duty comparator.
// - period code against bits 9..7; code 0 gives 1024, else code times 128.
// - the 10-bit duty register is compared with all counter bits.
// - enable rising clears the counter; falling stops it and keeps its value.
// - in compare mode enable rising sets the pin to its initial level.
// - pause holds the counter; clearing pause resumes from the held value.
// - clock select picks sys/4, sys, high/16, high/64, time base or pin edges.
// - mode select: 00 compare, 10 pwm, 11 timer; 01 is undefined.
// - compare mode duty match: no change, low, high or toggle.
// - pwm output function: inactive, active, waveform; 11 undefined.
// - initial level in compare mode, active level in pwm mode.
// - invert flips the pin; no effect in timer mode.
// - swap exchanges the period and duty roles in pwm mode.
// - clear on period match, or duty match and overflow; unused in pwm.
// - compare mode with period clear raises both flags on their matches.
// - outside pwm mode, with duty clear only the duty flag is ever raised.
// - duty clear and zero duty register overflow at 3ff without a flag.
// - in compare mode only duty matches and enable rising move the pin.
// - a requested level equal to the initial level leaves the pin alone.
// - timer mode leaves the pin undriven and counts like compare mode.
// - pwm duty at or above the period gives full duty.
// - pwm raises a flag for each comparator match.
// - the pwm waveform runs while the pin is forced to a level.
`timescale 1ns/1ps
`default_nettype none

module compact_timer_pwm (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// clock sources
	input  wire logic        tbc_tick,
	input  wire logic        ext_clk_pin,
	// output pin
	output var  logic        out_pin_o,
	output var  logic        out_pin_oe
);

	// ****************************************
	// registers
	// ****************************************
	timer_pkg::control0_t ctrl0;
	timer_pkg::control1_t ctrl1;
	logic [9:0]           duty_compare_value;
	logic [9:0]           count;
	logic                 flag_a;
	logic                 flag_p;
	logic                 en_d;
	logic                 out_level;
	logic [5:0]           presc;
	logic                 ext_s1;
	logic                 ext_s2;
	logic                 ext_d;

	// ****************************************
	// apb decode
	// ****************************************
	wire        acc      = psel & penable & pready;
	wire        wr_acc   = acc & pwrite;
	wire        setup    = psel & ~penable;
	wire        hit_c0   = (paddr == timer_pkg::OFS_CTRL0);
	wire        hit_c1   = (paddr == timer_pkg::OFS_CTRL1);
	wire        hit_cl   = (paddr == timer_pkg::OFS_CNT_LO);
	wire        hit_ch   = (paddr == timer_pkg::OFS_CNT_HI);
	wire        hit_al   = (paddr == timer_pkg::OFS_DUTY_LO);
	wire        hit_ah   = (paddr == timer_pkg::OFS_DUTY_HI);
	wire        hit_fl   = (paddr == timer_pkg::OFS_FLAGS);
	wire        mapped   = hit_c0 | hit_c1 | hit_cl | hit_ch |
	                       hit_al | hit_ah | hit_fl;
	wire [7:0]  rd_byte  = hit_c0 ? ctrl0 :
	                       hit_c1 ? ctrl1 :
	                       hit_cl ? count[7:0] :
	                       hit_ch ? {6'h00, count[9:8]} :
	                       hit_al ? duty_compare_value[7:0] :
	                       hit_ah ? {6'h00, duty_compare_value[9:8]} :
	                       hit_fl ? {6'h00, flag_p, flag_a} : 8'h00;

	// ****************************************
	// count clock selection
	// ****************************************
	wire       ext_rise = ext_s2 & ~ext_d;
	wire       ext_fall = ~ext_s2 & ext_d;
	wire       tick4    = ((presc & timer_pkg::PRE_MASK4) == timer_pkg::PRE_MASK4);
	wire       tick16   = ((presc & timer_pkg::PRE_MASK16) == timer_pkg::PRE_MASK16);
	wire       tick64   = ((presc & timer_pkg::PRE_MASK64) == timer_pkg::PRE_MASK64);
	logic      cnt_tick;

	always_comb begin
		unique case (ctrl0.clk_sel)
			timer_pkg::CK_SYS4: cnt_tick = tick4;
			timer_pkg::CK_SYS:  cnt_tick = 1'b1;
			timer_pkg::CK_H16:  cnt_tick = tick16;
			timer_pkg::CK_H64:  cnt_tick = tick64;
			timer_pkg::CK_TBC:  cnt_tick = tbc_tick;
			timer_pkg::CK_RSV:  cnt_tick = 1'b0;
			timer_pkg::CK_EXTR: cnt_tick = ext_rise;
			timer_pkg::CK_EXTF: cnt_tick = ext_fall;
		endcase
	end

	// ****************************************
	// comparators
	// ****************************************
	wire        is_cmp   = (ctrl1.mode_sel == timer_pkg::MODE_CMP);
	wire        is_pwm   = (ctrl1.mode_sel == timer_pkg::MODE_PWM);
	wire        is_tc    = (ctrl1.mode_sel == timer_pkg::MODE_TC);
	wire        en_rise  = ctrl0.count_enable & ~en_d;
	wire        run      = cnt_tick & ctrl0.count_enable & ~ctrl0.pause_ctl;
	wire [10:0] inc      = {1'b0, count} + 11'h001;
	wire [9:0]  per_top  = {ctrl0.period_code, 7'h00};
	wire        p_hit    = (ctrl0.period_code != 3'h0) ? (inc[9:0] == per_top)
	                                                  : inc[10];
	wire        a_hit    = (duty_compare_value != 10'h000) &&
	                       (inc[9:0] == duty_compare_value);
	wire        clr_duty = is_pwm ? ctrl1.period_duty_swap
	                              : ctrl1.clear_sel;
	wire        a_set    = run & a_hit;
	wire        p_set    = run & p_hit & (is_pwm | ~ctrl1.clear_sel);
	wire        ovf      = run & inc[10];
	wire        do_clr   = clr_duty ? (run & a_hit) | ovf : run & p_hit;
	wire [9:0]  next_count = en_rise ? timer_pkg::RST_COUNT :
	                         do_clr  ? 10'h000 :
	                         run     ? inc[9:0] : count;

	// ****************************************
	// pwm waveform, always generated
	// ****************************************
	wire [10:0] code_len = (ctrl0.period_code == 3'h0) ? 11'h400
	                       : {1'b0, per_top};
	wire [10:0] duty_compare_value_len = (duty_compare_value == 10'h000) ? 11'h400
	                       : {1'b0, duty_compare_value};
	wire [10:0] duty_len = ctrl1.period_duty_swap ? code_len : duty_compare_value_len;
	wire        pwm_act  = ({1'b0, count} < duty_len);
	wire        pwm_wave = pwm_act ? ctrl1.out_init : ~ctrl1.out_init;

	// ****************************************
	// compare output level
	// ****************************************
	logic next_level;

	always_comb begin
		next_level = out_level;
		if (en_rise && is_cmp) begin
			next_level = ctrl1.out_init;
		end else if (a_set) begin
			unique case (ctrl1.out_func)
				2'b00: next_level = out_level;
				2'b01: next_level = 1'b0;
				2'b10: next_level = 1'b1;
				2'b11: next_level = ~out_level;
			endcase
		end
	end

	logic pin_raw;

	always_comb begin
		pin_raw = out_level;
		if (is_pwm) begin
			unique case (ctrl1.out_func)
				2'b00: pin_raw = ~ctrl1.out_init;
				2'b01: pin_raw = ctrl1.out_init;
				2'b10: pin_raw = pwm_wave;
				2'b11: pin_raw = ~ctrl1.out_init;
			endcase
		end
	end

	wire next_pin = pin_raw ^ ctrl1.out_invert;
	wire next_oe  = is_cmp | is_pwm;

	// ****************************************
	// flags: write one to clear, set wins
	// ****************************************
	wire clr_fa = wr_acc & hit_fl & pwdata[timer_pkg::FLAG_A_BIT];
	wire clr_fp = wr_acc & hit_fl & pwdata[timer_pkg::FLAG_P_BIT];
	wire next_fa = a_set | (flag_a & ~clr_fa);
	wire next_fp = p_set | (flag_p & ~clr_fp);

	// ****************************************
	// apb answer
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
		end
	end

	// ****************************************
	// software registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0 <= timer_pkg::RST_CTRL0;
			ctrl1 <= timer_pkg::RST_CTRL1;
			duty_compare_value <= timer_pkg::RST_DUTY;
		end else begin
			if (wr_acc && hit_c0)
				ctrl0 <= pwdata[7:0];
			if (wr_acc && hit_c1)
				ctrl1 <= pwdata[7:0];
			if (wr_acc && hit_al)
				duty_compare_value[7:0] <= pwdata[7:0];
			if (wr_acc && hit_ah)
				duty_compare_value[9:8] <= pwdata[1:0];
		end
	end

	// ****************************************
	// pin synchroniser and prescaler
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_d  <= 1'b0;
			presc  <= 6'h00;
		end else begin
			ext_s1 <= ext_clk_pin;
			ext_s2 <= ext_s1;
			ext_d  <= ext_s2;
			presc  <= presc + 6'h01;
		end
	end

	// ****************************************
	// counter, flags and pin
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count      <= timer_pkg::RST_COUNT;
			en_d       <= 1'b0;
			flag_a     <= 1'b0;
			flag_p     <= 1'b0;
			out_level  <= 1'b0;
			out_pin_o  <= 1'b0;
			out_pin_oe <= 1'b0;
		end else begin
			count      <= next_count;
			en_d       <= ctrl0.count_enable;
			flag_a     <= next_fa;
			flag_p     <= next_fp;
			out_level  <= next_level;
			out_pin_o  <= next_pin;
			out_pin_oe <= next_oe;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence on_rise_s;
		ctrl0.count_enable && !en_d;
	endsequence

	sequence stepping_s;
		run && !do_clr && !en_rise;
	endsequence

	cnt_clear_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		on_rise_s |=> (count == 10'h000))
		else $error("counter not cleared on enable rise");

	pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl0.pause_ctl && !en_rise) |=> (count == $past(count)))
		else $error("counter moved while paused");

	init_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		(on_rise_s and is_cmp) |=> (out_level == $past(ctrl1.out_init)))
		else $error("pin level not initialised");

	count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		stepping_s |=> (count == $past(count) + 10'h001))
		else $error("counter did not step");

	no_flag_p_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!is_pwm && ctrl1.clear_sel && !flag_p) |=> !flag_p)
		else $error("period flag raised with duty clear");

	ovf_no_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && count == 10'h3ff && duty_compare_value == 10'h000 && !flag_a)
		|=> (!flag_a && count == 10'h000))
		else $error("overflow raised the duty flag");

	flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		a_set |=> flag_a)
		else $error("duty match lost its flag");

	timer_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		is_tc |=> !out_pin_oe)
		else $error("pin driven in timer mode");

	full_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
		(is_pwm && ctrl1.out_func == 2'b10 && duty_len >= code_len
		 && !ctrl1.period_duty_swap)
		|=> (out_pin_o == ($past(ctrl1.out_init) ^ $past(ctrl1.out_invert))))
		else $error("full duty not held");

	sequence cmp_match_s;
		is_cmp && a_set && !en_rise;
	endsequence

	flag_p_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		p_set |=> flag_p)
		else $error("period match lost its flag");

	flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clr_fa && !a_set) |=> !flag_a)
		else $error("duty flag not cleared");

	pin_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
		(is_cmp || is_pwm) |=> out_pin_oe)
		else $error("pin not driven");

	match_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cmp_match_s and (ctrl1.out_func == 2'b01)) |=> !out_level)
		else $error("match did not drive low");

	match_high_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cmp_match_s and (ctrl1.out_func == 2'b10)) |=> out_level)
		else $error("match did not drive high");

	match_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cmp_match_s and (ctrl1.out_func == 2'b11)) |=> (out_level != $past(out_level)))
		else $error("match did not toggle");

	level_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(is_cmp && !a_set && !en_rise) |=> (out_level == $past(out_level)))
		else $error("level moved without duty match");

	cmp_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		is_cmp |=> (out_pin_o == ($past(out_level) ^ $past(ctrl1.out_invert))))
		else $error("compare pin does not follow level");

	period_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && p_hit && (is_pwm ? !ctrl1.period_duty_swap : !ctrl1.clear_sel))
		|=> (count == 10'h000))
		else $error("period match did not clear");

	duty_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && a_hit && (is_pwm ? ctrl1.period_duty_swap : ctrl1.clear_sel))
		|=> (count == 10'h000))
		else $error("duty match did not clear");

	pwm_forced_a: assert property (@(posedge pclk) disable iff (!presetn)
		(is_pwm && ctrl1.out_func == 2'b01)
		|=> (out_pin_o == ($past(ctrl1.out_init) ^ $past(ctrl1.out_invert))))
		else $error("pwm active level not held");

	pwm_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		(is_pwm && ctrl1.out_func == 2'b00)
		|=> (out_pin_o == ($past(ctrl1.out_init) ~^ $past(ctrl1.out_invert))))
		else $error("pwm inactive level not held");

endmodule : compact_timer_pwm

`default_nettype wire

// file: timer_pkg.sv
// Purpose: shared constants and types for the compact timer
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   byte offsets, field layouts and reset values live here
package timer_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [11:0] OFS_CTRL0    = 12'h000;
	localparam logic [11:0] OFS_CTRL1    = 12'h004;
	localparam logic [11:0] OFS_CNT_LO   = 12'h008;
	localparam logic [11:0] OFS_CNT_HI   = 12'h00c;
	localparam logic [11:0] OFS_DUTY_LO  = 12'h010;
	localparam logic [11:0] OFS_DUTY_HI  = 12'h014;
	localparam logic [11:0] OFS_FLAGS    = 12'h018;

	// ****************************************
	// reset values and field positions
	// ****************************************
	localparam logic [7:0]  RST_CTRL0    = 8'h00;
	localparam logic [7:0]  RST_CTRL1    = 8'h00;
	localparam logic [9:0]  RST_DUTY     = 10'h000;
	localparam logic [9:0]  RST_COUNT    = 10'h000;
	localparam int          FLAG_A_BIT   = 0;
	localparam int          FLAG_P_BIT   = 1;
	localparam int          PERIOD_SHIFT = 7;

	// ****************************************
	// prescaler masks: tick every 4, 16, 64 clocks
	// ****************************************
	localparam logic [5:0]  PRE_MASK4    = 6'h03;
	localparam logic [5:0]  PRE_MASK16   = 6'h0f;
	localparam logic [5:0]  PRE_MASK64   = 6'h3f;

	typedef enum logic [1:0] {
		MODE_CMP = 2'b00,
		MODE_UND = 2'b01,
		MODE_PWM = 2'b10,
		MODE_TC  = 2'b11
	} mode_t;

	typedef enum logic [2:0] {
		CK_SYS4 = 3'b000,
		CK_SYS  = 3'b001,
		CK_H16  = 3'b010,
		CK_H64  = 3'b011,
		CK_TBC  = 3'b100,
		CK_RSV  = 3'b101,
		CK_EXTR = 3'b110,
		CK_EXTF = 3'b111
	} clk_sel_t;

	typedef struct packed {
		logic       pause_ctl;
		clk_sel_t   clk_sel;
		logic       count_enable;
		logic [2:0] period_code;
	} control0_t;

	typedef struct packed {
		mode_t      mode_sel;
		logic [1:0] out_func;
		logic       out_init;
		logic       out_invert;
		logic       period_duty_swap;
		logic       clear_sel;
	} control1_t;

endpackage : timer_pkg

// file: ext_side.sv
// Purpose: far side of the timer: external count pin and time-base ticks
// Assumes: run inputs change just after a pclk edge
// Notes:   pin rests low between bursts; one edge pair per 8 clocks
`timescale 1ns/1ps
`default_nettype none

module ext_side (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// burst requests
	input  wire logic ext_run,
	input  wire logic tbc_run,
	// toward the timer
	output var  logic ext_clk_pin,
	output var  logic tbc_tick
);
	logic [2:0] phase;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase <= 3'h0;
		else if (ext_run | tbc_run)
			phase <= phase + 3'h1;
		else
			phase <= 3'h0;
	end

	// five rising and five falling edges, five ticks per 40 clocks
	assign ext_clk_pin = ext_run & phase[2];
	assign tbc_tick    = tbc_run & (phase == 3'h3);
endmodule : ext_side

`default_nettype wire

// file: test_compact_timer_pwm.sv
// Purpose: self-checking bench for the compact timer over apb
// Assumes: zero-wait apb slave, offsets from timer_pkg
// Notes:   pin checks sample out_pin_o at clock edges
`timescale 1ns/1ps
`default_nettype none

module test_compact_timer_pwm;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        ext_run, tbc_run, ext_clk_pin, tbc_tick, out_pin_o, out_pin_oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0]  c, hold;
	int          error_cnt, samples_checked, i, hi;
	logic [7:0]  cmp_c1 [5] = '{8'h00, 8'h18, 8'h20, 8'h28, 8'h1c};
	logic        cmp_fin [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	int          sel_lo [8] = '{63, 258, 15, 3, 5, 0, 5, 5};
	logic [9:0]  pwm_d [7] = '{10'h040, 10'h040, 10'h040, 10'h200, 10'h020, 10'h100, 10'h020};
	logic [7:0]  pwm_c [7] = '{8'h88, 8'h98, 8'ha8, 8'ha8, 8'ha0, 8'haa, 8'hac};
	int          pwm_e [7] = '{0, 256, 128, 256, 192, 128, 192};

	compact_timer_pwm u_compact_timer_pwm (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tbc_tick(tbc_tick), .ext_clk_pin(ext_clk_pin),
		.out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe));
	ext_side u_ext_side (.pclk(pclk), .presetn(presetn), .ext_run(ext_run),
		.tbc_run(tbc_run), .ext_clk_pin(ext_clk_pin), .tbc_tick(tbc_tick));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ****************************************
	// bus and compare tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
		check(err, 32'h0);
	endtask : rchk

	task automatic setup(input logic [7:0] c0, input logic [7:0] c1);
		apb(1'b1, timer_pkg::OFS_CTRL0, 32'h0);
		apb(1'b1, timer_pkg::OFS_FLAGS, 32'h3);
		apb(1'b1, timer_pkg::OFS_CTRL1, {24'h0, c1});
		apb(1'b1, timer_pkg::OFS_CTRL0, {24'h0, c0});
	endtask : setup

	task automatic duty(input logic [9:0] v);
		apb(1'b1, timer_pkg::OFS_DUTY_LO, {24'h0, v[7:0]});
		apb(1'b1, timer_pkg::OFS_DUTY_HI, {30'h0, v[9:8]});
	endtask : duty

	task automatic rcount;
		apb(1'b0, timer_pkg::OFS_CNT_LO, 32'h0);
		c[7:0] = rd[7:0];
		apb(1'b0, timer_pkg::OFS_CNT_HI, 32'h0);
		c[9:8] = rd[1:0];
	endtask : rcount

	task automatic count_high(input int n);
		hi = 0;
		repeat (n) begin
			@(posedge pclk);
			hi += int'(out_pin_o);
			if ($isunknown(out_pin_o))
				check(32'(out_pin_o), 32'h0);
		end
	endtask : count_high

	task automatic tally_and_finish;
		$display("mismatches %0d of %0d checks", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	initial begin
		#(25 * 30000);
		error_cnt++;
		tally_and_finish();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		{psel, penable, pwrite, presetn, ext_run, tbc_run} = 6'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 7; i++)
			rchk(12'(4 * i), 32'h0);
		apb(1'b0, 12'h01c, 32'h0);
		check({rd[30:0], err}, 32'h1);
		apb(1'b1, timer_pkg::OFS_CNT_LO, 32'h55);
		rchk(timer_pkg::OFS_CNT_LO, 32'h0);
		duty(10'h2a5);
		rchk(timer_pkg::OFS_DUTY_LO, 32'ha5);
		rchk(timer_pkg::OFS_DUTY_HI, 32'h2);
		duty(10'h040);
		for (i = 0; i < 5; i++) begin
			setup(8'h99, cmp_c1[i]);
			repeat (4) @(posedge pclk);
			check(out_pin_o, cmp_c1[i][3] ^ cmp_c1[i][2]);
			check(out_pin_oe, 32'h1);
			apb(1'b1, timer_pkg::OFS_CTRL0, 32'h19);
			repeat (200) @(posedge pclk);
			check(out_pin_o, cmp_fin[i]);
		end
		setup(8'h19, 8'h30);
		count_high(256);
		check(hi, 32'd128);
		setup(8'h19, 8'h00);
		repeat (300) @(posedge pclk);
		rchk(timer_pkg::OFS_FLAGS, 32'h3);
		setup(8'h19, 8'hc0);
		repeat (300) @(posedge pclk);
		check(out_pin_oe, 32'h0);
		rchk(timer_pkg::OFS_FLAGS, 32'h3);
		setup(8'h19, 8'h40);
		repeat (4) @(posedge pclk);
		check(out_pin_oe, 32'h0);
		duty(10'h100);
		setup(8'h19, 8'h01);
		repeat (600) @(posedge pclk);
		rchk(timer_pkg::OFS_FLAGS, 32'h1);
		duty(10'h000);
		setup(8'h19, 8'h01);
		repeat (1100) @(posedge pclk);
		rchk(timer_pkg::OFS_FLAGS, 32'h0);
		setup(8'h99, 8'h00);
		rcount();
		check(c, 32'h0);
		apb(1'b1, timer_pkg::OFS_CTRL0, 32'h19);
		repeat (30) @(posedge pclk);
		apb(1'b1, timer_pkg::OFS_CTRL0, 32'h99);
		rcount();
		hold = c;
		repeat (40) @(posedge pclk);
		rcount();
		check(c, hold);
		apb(1'b1, timer_pkg::OFS_CTRL0, 32'h11);
		rcount();
		check(c, hold);
		apb(1'b1, timer_pkg::OFS_CTRL0, 32'h19);
		apb(1'b1, timer_pkg::OFS_CTRL0, 32'h99);
		rcount();
		check(c < 10'd16, 32'h1);
		for (i = 0; i < 8; i++) begin
			setup({1'b1, 3'(i), 4'h8}, 8'h00);
			apb(1'b1, timer_pkg::OFS_CTRL0, {24'h0, 1'b0, 3'(i), 4'h8});
			ext_run <= 1'b1;
			tbc_run <= 1'b1;
			repeat (40) @(posedge pclk);
			ext_run <= 1'b0;
			tbc_run <= 1'b0;
			repeat (216) @(posedge pclk);
			apb(1'b1, timer_pkg::OFS_CTRL0, {24'h0, 1'b1, 3'(i), 4'h8});
			rcount();
			check(32'(c) - sel_lo[i] <= 2, 32'h1);
		end
		for (i = 0; i < 7; i++) begin
			duty(pwm_d[i]);
			setup(8'h19, pwm_c[i]);
			repeat (20) @(posedge pclk);
			count_high(256);
			check(hi, pwm_e[i]);
			if (i == 0)
				rchk(timer_pkg::OFS_FLAGS, 32'h3);
		end
		tally_and_finish();
	end
endmodule : test_compact_timer_pwm

`default_nettype wire
